// File: verilog/vpr_cfg.svh
`ifndef VPR_CFG_SVH
`define VPR_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define VPR_ADDR_ELEV     8'h00
`define VPR_ADDR_WDOG     8'h01
`define VPR_ADDR_FLAGS    8'h02
`define VPR_ADDR_STATUS   8'h03
`define VPR_ADDR_VECLO    8'h04
`define VPR_ADDR_EN_BASE  5'h01

// ****************************************
// Reset values
// ****************************************
`define VPR_RST_ELEV      8'hF2
`define VPR_RST_WDOG      8'h80
`define VPR_RST_FLAGS     5'h00
`define VPR_RST_EN        64'h0000_0000_0000_0000

// ****************************************
// Field positions
// ****************************************
`define VPR_WDOG_CLKMON_EN  7
`define VPR_WDOG_CLKMON_FRC 6
`define VPR_WDOG_RATE_HI  2
`define VPR_FLAG_POR      0
`define VPR_FLAG_EXT      1
`define VPR_FLAG_LVR      2
`define VPR_FLAG_CLKMON   3
`define VPR_FLAG_WDOG     4
`define VPR_SYNC_POR      0
`define VPR_SYNC_EXT      1
`define VPR_SYNC_LVR      2
`define VPR_SYNC_NMI      3

// ****************************************
// Vector addresses
// ****************************************
`define VPR_VEC_POWER     16'hFFFE
`define VPR_VEC_CLKMON    16'hFFFC
`define VPR_VEC_WDOG      16'hFFFA
`define VPR_VEC_TRAP      16'hFFF8
`define VPR_VEC_SWI       16'hFFF6
`define VPR_VEC_NMI       16'hFFF4
`define VPR_VEC_MASK_TOP  16'hFFF2
`define VPR_ELEV_TOP      8'hF2
`define VPR_MASK_COUNT    58
`define VPR_MASK_IMPL     58'h014_0003_E0C5_7FF3

`endif

// File: verilog/vpr_pkg.sv
package vpr_pkg;

	typedef enum logic [2:0] {
		KIND_NONE,
		KIND_RESET,
		KIND_CLKMON,
		KIND_WDOG,
		KIND_TRAP,
		KIND_SWI,
		KIND_NMI,
		KIND_MASK
	} vec_kind_e;

	typedef struct packed {
		logic [3:0]  sync1;
		logic [3:0]  sync2;
		logic [7:0]  elev;
		logic [7:0]  wdog_ctl;
		logic [4:0]  flags;
		logic [63:0] en;
		logic [7:0]  rdata;
		logic [15:0] vec;
		logic        valid;
		logic        rst_req;
		vec_kind_e   kind;
	} vpr_state_s;

endpackage : vpr_pkg

// File: verilog/irq_bus_if.sv
interface irq_bus_if #(
	parameter int N = 58
);
	logic [N-1:0] pend;
	logic [N-1:0] en;
	logic         i_bit;
	logic [N-1:0] elig;
	logic [7:0]   elev_val;
	logic         hit;
	logic [5:0]   idx;

	modport gate (input pend, input en, input i_bit, output elig);
	modport pick (input elig, input elev_val, output hit, output idx);
	modport ctrl (output pend, output en, output i_bit, output elev_val, input hit, input idx, input elig);
endinterface : irq_bus_if

// File: verilog/irq_source_gate.sv
`include "vpr_cfg.svh"

module irq_source_gate #(
	parameter int         N    = `VPR_MASK_COUNT,
	parameter logic [N-1:0] IMPL = `VPR_MASK_IMPL
) (
	irq_bus_if.gate bus
);
	// ****************************************
	// Per-source masking
	// ****************************************
	genvar k;
	generate
		for (k = 0; k < N; k++) begin : g_src
			// Reserved slots are hard zero whatever the request lines do
			assign bus.elig[k] = IMPL[k] & bus.pend[k] & bus.en[k] & ~bus.i_bit;
		end
	endgenerate
endmodule : irq_source_gate

// File: verilog/irq_prio_pick.sv
`include "vpr_cfg.svh"

module irq_prio_pick #(
	parameter int N = `VPR_MASK_COUNT
) (
	irq_bus_if.pick bus
);
	logic [7:0] diff;
	logic [5:0] eidx;
	logic       eok;

	// ****************************************
	// Elevation decode
	// ****************************************
	always_comb begin
		diff = `VPR_ELEV_TOP - bus.elev_val;
		eidx = diff[6:1];
		eok  = (bus.elev_val[0] == 1'b0) && (bus.elev_val <= `VPR_ELEV_TOP) && (int'(diff[7:1]) < N);
	end

	// ****************************************
	// Winner selection
	// ****************************************
	always_comb begin
		bus.hit = 1'b0;
		bus.idx = 6'h00;
		// Lower index is the higher vector, so scan down and let the last win
		for (int i = N - 1; i >= 0; i--) begin
			if (bus.elig[i]) begin
				bus.hit = 1'b1;
				bus.idx = 6'(i);
			end
		end
		// Elevated source beats every other maskable one
		if (eok && bus.elig[eidx]) begin
			bus.hit = 1'b1;
			bus.idx = eidx;
		end
	end
endmodule : irq_prio_pick

// File: verilog/vector_priority_and_reset_map.sv
// The implementer's own choices: the placing of the registers and strobed register access.
`include "vpr_cfg.svh"

module vector_priority_and_reset_map
	import vpr_pkg::*;
#(
	parameter int N = `VPR_MASK_COUNT
) (
	// Clock and reset
	input  wire logic         CLK_I,
	input  wire logic         RST_I,
	// Reset sources
	input  wire logic         POR_I,
	input  wire logic         RESET_PIN_N_I,
	input  wire logic         LVR_I,
	input  wire logic         CLKMON_FAIL_I,
	input  wire logic         WDOG_FAIL_I,
	// Exception sources
	input  wire logic         TRAP_I,
	input  wire logic         SWI_I,
	input  wire logic         NMI_PIN_N_I,
	input  wire logic [N-1:0] IRQ_REQ_I,
	// Core condition-code masks
	input  wire logic         I_BIT_I,
	input  wire logic         X_BIT_I,
	// Register port
	input  wire logic [7:0]   ADDR_I,
	input  wire logic [7:0]   WDATA_I,
	input  wire logic         WR_I,
	input  wire logic         RD_I,
	output logic      [7:0]   RDATA_O,
	// Vector to the core
	output logic      [15:0]  VEC_ADDR_O,
	output logic              VEC_VALID_O,
	output logic              SYS_RESET_O,
	output logic      [2:0]   VEC_KIND_O
);

	// ****************************************
	// Parameter check
	// ****************************************
	// The winner index is six bits and the enable bank 64 bits wide,
	// so more slots would need wider registers, not just a new parameter
	generate
		if (N < 1 || N > 64) begin : g_bad_n
			$error("N must lie between 1 and 64");
		end
	endgenerate

	// ****************************************
	// State
	// ****************************************
	vpr_state_s st_r;
	vpr_state_s st_nxt;

	irq_bus_if #(.N(N)) bus ();

	// Reserved slots are fixed at build time so no register write can bring one to life
	irq_source_gate #(
		.N    (N),
		.IMPL (N'(`VPR_MASK_IMPL))
	) u_gate (
		.bus (bus.gate)
	);

	irq_prio_pick #(
		.N (N)
	) u_pick (
		.bus (bus.pick)
	);

	// ****************************************
	// Register address decode
	// ****************************************
	logic       sel_flags;
	logic       sel_en;
	logic [2:0] en_byte;

	always_comb begin
		sel_flags = (ADDR_I == `VPR_ADDR_FLAGS);
		sel_en    = (ADDR_I[7:3] == `VPR_ADDR_EN_BASE);
		// The low address bits pick one byte of the enable bank
		en_byte   = ADDR_I[2:0];
	end

	// ****************************************
	// Source qualification
	// ****************************************
	logic       por_s;
	logic       ext_s;
	logic       lvr_s;
	logic       nmi_s;
	logic       power_rst;
	logic       clkmon_rst;
	logic       wdog_rst;
	logic       any_rst;
	logic       nmi_req;
	logic [4:0] flag_set;
	logic [4:0] flag_clr;

	always_comb begin
		por_s = st_r.sync2[`VPR_SYNC_POR];
		ext_s = st_r.sync2[`VPR_SYNC_EXT];
		lvr_s = st_r.sync2[`VPR_SYNC_LVR];
		nmi_s = st_r.sync2[`VPR_SYNC_NMI];
		// Levels: power group one, clock monitor two, watchdog three
		power_rst  = por_s | ext_s | lvr_s;
		// Condition-code bits play no part here
		clkmon_rst = CLKMON_FAIL_I & (st_r.wdog_ctl[`VPR_WDOG_CLKMON_EN] | st_r.wdog_ctl[`VPR_WDOG_CLKMON_FRC]);
		// A zero rate means the watchdog is off
		wdog_rst   = WDOG_FAIL_I & (|st_r.wdog_ctl[`VPR_WDOG_RATE_HI:0]);
		any_rst    = power_rst | clkmon_rst | wdog_rst;
		// The pin request waits for the X bit alone; the I bit never holds it back
		nmi_req    = nmi_s & ~X_BIT_I;
		flag_set   = 5'h00;
		flag_set[`VPR_FLAG_POR]    = por_s;
		flag_set[`VPR_FLAG_EXT]    = ext_s;
		flag_set[`VPR_FLAG_LVR]    = lvr_s;
		flag_set[`VPR_FLAG_CLKMON] = clkmon_rst;
		flag_set[`VPR_FLAG_WDOG]   = wdog_rst;
		// Write one to clear; a bit being set in the same cycle survives
		flag_clr = (WR_I && sel_flags) ? WDATA_I[4:0] : 5'h00;
	end

	// ****************************************
	// Interface drive
	// ****************************************
	// The gate sees the live I bit, so masking takes effect on the next edge
	always_comb begin
		bus.pend     = IRQ_REQ_I;
		bus.en       = st_r.en[N-1:0];
		bus.i_bit    = I_BIT_I;
		bus.elev_val = st_r.elev;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;

		// Pins and analog sources cross into the clock domain here
		// Only the second stage feeds logic; the first may still be settling
		st_nxt.sync1[`VPR_SYNC_POR] = POR_I;
		st_nxt.sync1[`VPR_SYNC_EXT] = ~RESET_PIN_N_I;
		st_nxt.sync1[`VPR_SYNC_LVR] = LVR_I;
		st_nxt.sync1[`VPR_SYNC_NMI] = ~NMI_PIN_N_I;
		st_nxt.sync2 = st_r.sync1;

		// Flags survive a source-triggered reset (only RST_I or a write of one clears them) so software can tell the sources apart; set beats clear
		st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;

		// ****************************************
		// Register writes
		// ****************************************
		if (WR_I) begin
			case (ADDR_I)
				`VPR_ADDR_ELEV: begin
					// Stored as written; the picker ignores a value it cannot map
					st_nxt.elev = WDATA_I;
				end
				`VPR_ADDR_WDOG: begin
					// A zero rate field switches the watchdog reset off
					st_nxt.wdog_ctl = WDATA_I;
				end
				default: begin
					if (sel_en) begin
						st_nxt.en[{en_byte, 3'b000} +: 8] = WDATA_I;
					end
				end
			endcase
		end

		// ****************************************
		// Read data
		// ****************************************
		// Read data stand for one cycle only; idle zero keeps a stale value from passing as fresh
		st_nxt.rdata = 8'h00;
		if (RD_I) begin
			case (ADDR_I)
				`VPR_ADDR_ELEV: begin
					st_nxt.rdata = st_r.elev;
				end
				`VPR_ADDR_WDOG: begin
					st_nxt.rdata = st_r.wdog_ctl;
				end
				`VPR_ADDR_FLAGS: begin
					st_nxt.rdata = {3'b000, st_r.flags};
				end
				`VPR_ADDR_STATUS: begin
					// Lets software poll the pending vector without a core fetch
					st_nxt.rdata = {st_r.valid, st_r.rst_req, 3'b000, st_r.kind};
				end
				`VPR_ADDR_VECLO: begin
					st_nxt.rdata = st_r.vec[7:0];
				end
				default: begin
					if (sel_en) begin
						st_nxt.rdata = st_r.en[{en_byte, 3'b000} +: 8];
					end
				end
			endcase
		end

		// ****************************************
		// Vector selection, highest first
		// ****************************************
		// Every vector is even; the core fetches the high byte there and the low byte one above
		// Trap, software interrupt and the pin request are never elevated
		st_nxt.rst_req = any_rst;
		st_nxt.valid   = 1'b1;
		if (power_rst) begin
			st_nxt.vec  = `VPR_VEC_POWER;
			st_nxt.kind = KIND_RESET;
		end else if (clkmon_rst) begin
			st_nxt.vec  = `VPR_VEC_CLKMON;
			st_nxt.kind = KIND_CLKMON;
		end else if (wdog_rst) begin
			st_nxt.vec  = `VPR_VEC_WDOG;
			st_nxt.kind = KIND_WDOG;
		end else if (TRAP_I) begin
			st_nxt.vec  = `VPR_VEC_TRAP;
			st_nxt.kind = KIND_TRAP;
		end else if (SWI_I) begin
			st_nxt.vec  = `VPR_VEC_SWI;
			st_nxt.kind = KIND_SWI;
		end else if (nmi_req) begin
			st_nxt.vec  = `VPR_VEC_NMI;
			st_nxt.kind = KIND_NMI;
		end else if (bus.hit) begin
			st_nxt.vec  = `VPR_VEC_MASK_TOP - {9'h000, bus.idx, 1'b0};
			st_nxt.kind = KIND_MASK;
		end else begin
			st_nxt.vec   = 16'h0000;
			st_nxt.kind  = KIND_NONE;
			st_nxt.valid = 1'b0;
		end

		// ****************************************
		// Start-up values
		// ****************************************
		// Any reset source puts the control registers back to start-up values.
		// There is deliberately no RAM clear path: RAM keeps its contents
		if (any_rst) begin
			st_nxt.elev     = `VPR_RST_ELEV;
			st_nxt.wdog_ctl = `VPR_RST_WDOG;
			st_nxt.en       = `VPR_RST_EN;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Synchronous system reset only; reset-source pins restore
	// the registers through the next-state logic instead
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			st_r.sync1    <= 4'h0;
			st_r.sync2    <= 4'h0;
			st_r.elev     <= `VPR_RST_ELEV;
			st_r.wdog_ctl <= `VPR_RST_WDOG;
			st_r.flags    <= `VPR_RST_FLAGS;
			st_r.en       <= `VPR_RST_EN;
			st_r.rdata    <= 8'h00;
			st_r.vec      <= 16'h0000;
			st_r.valid    <= 1'b0;
			st_r.rst_req  <= 1'b0;
			st_r.kind     <= KIND_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Each output is a register bit with no logic behind it
	always_comb begin
		RDATA_O     = st_r.rdata;
		VEC_ADDR_O  = st_r.vec;
		VEC_VALID_O = st_r.valid;
		SYS_RESET_O = st_r.rst_req;
		VEC_KIND_O  = st_r.kind;
	end

endmodule : vector_priority_and_reset_map

// File: verification/vpr_props.sv
module vpr_props (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        TRAP_I,
	input wire logic        SWI_I,
	input wire logic        I_BIT_I,
	input wire logic        RD_I,
	input wire logic [7:0]  RDATA_O,
	input wire logic [15:0] VEC_ADDR_O,
	input wire logic        VEC_VALID_O,
	input wire logic        SYS_RESET_O,
	input wire logic [2:0]  VEC_KIND_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	// ****
	// Exception ordering, vector and read-data checks
	// ****
	sequence s_swi_only;
		SWI_I && !TRAP_I;
	endsequence
	sequence s_no_reset;
		!SYS_RESET_O;
	endsequence
	a_swi_wins: assert property (s_swi_only ##1 s_no_reset |-> VEC_KIND_O == 3'h5)
		else $error("swi not chosen");
	a_rdata_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
		else $error("read data not idle");
	a_vec_even: assert property (VEC_VALID_O |-> !VEC_ADDR_O[0] && VEC_ADDR_O[15:8] == 8'hFF)
		else $error("vector not even");
	a_idle_zero: assert property (!VEC_VALID_O |-> VEC_ADDR_O == 16'h0000 && VEC_KIND_O == 3'h0)
		else $error("idle vector not zero");
	a_reset_vec: assert property (VEC_KIND_O == 3'h1 |-> VEC_ADDR_O == 16'hFFFE && SYS_RESET_O)
		else $error("reset vector wrong");
	a_clkmon_vec: assert property (VEC_KIND_O == 3'h2 |-> VEC_ADDR_O == 16'hFFFC && SYS_RESET_O)
		else $error("clock monitor vector wrong");
	a_wdog_vec: assert property (VEC_KIND_O == 3'h3 |-> VEC_ADDR_O == 16'hFFFA && SYS_RESET_O)
		else $error("watchdog vector wrong");
	a_imask_holds: assert property (I_BIT_I |=> VEC_KIND_O != 3'h7)
		else $error("maskable taken under mask");
	a_mask_range: assert property (VEC_KIND_O == 3'h7 |-> VEC_ADDR_O <= 16'hFFF2 && !SYS_RESET_O)
		else $error("maskable vector out of range");
endmodule : vpr_props

bind vector_priority_and_reset_map vpr_props vpr_props_inst (.CLK_I(CLK_I), .RST_I(RST_I), .TRAP_I(TRAP_I),
	.SWI_I(SWI_I), .I_BIT_I(I_BIT_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .VEC_ADDR_O(VEC_ADDR_O),
	.VEC_VALID_O(VEC_VALID_O), .SYS_RESET_O(SYS_RESET_O), .VEC_KIND_O(VEC_KIND_O));

// File: verification/core_model.sv
module core_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] vec_i,
	input  wire logic        valid_i,
	output logic      [15:0] fetch_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// High byte is fetched first, so the even byte opens the pair
	always @(posedge clk_i) begin
		if (valid_i) begin
			fetch_o <= {vec_i[15:1], 1'b0};
		end
	end
endmodule : core_model

// File: verification/vector_priority_and_reset_map_tb_top.sv
module vector_priority_and_reset_map_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0, rst = 1'h1, por = 1'h0, pin_n = 1'h1, lvr = 1'h0;
	logic        cmf = 1'h0, wdf = 1'h0, trap = 1'h0, swi = 1'h0, nmi_n = 1'h1;
	logic        ib = 1'h0, xb = 1'h0, wr = 1'h0, rd = 1'h0;
	logic [57:0] irq = 58'h0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
	logic [15:0] vec, fetch;
	logic        valid, sysrst;
	logic [2:0]  kind;
	int          err_total = 0, tests_run = 0, cyc = 0;
	always #20 clk = ~clk;
	vector_priority_and_reset_map vector_priority_and_reset_map_inst (.CLK_I(clk), .RST_I(rst),
		.POR_I(por), .RESET_PIN_N_I(pin_n), .LVR_I(lvr), .CLKMON_FAIL_I(cmf), .WDOG_FAIL_I(wdf),
		.TRAP_I(trap), .SWI_I(swi), .NMI_PIN_N_I(nmi_n), .IRQ_REQ_I(irq), .I_BIT_I(ib), .X_BIT_I(xb),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .VEC_ADDR_O(vec),
		.VEC_VALID_O(valid), .SYS_RESET_O(sysrst), .VEC_KIND_O(kind));
	core_model core_model_inst (.clk_i(clk), .vec_i(vec), .valid_i(valid), .fetch_o(fetch));
	task automatic complete_run;
		$display("Checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// Hang guard; the sequence needs well under 300 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		chk(16'(rdata), 16'(d));
	endtask : rd_reg
	task automatic vchk(input logic [15:0] a, input logic [2:0] k);
		@(posedge clk);
		#1;
		chk(vec, a);
		chk(16'(kind), 16'(k));
		chk(16'(valid), 16'(a != 16'h0000));
		chk(16'(sysrst), 16'(k inside {3'h1, 3'h2, 3'h3}));
	endtask : vchk
	task automatic t_regs;
		rd_reg(8'h00, 8'hF2);
		rd_reg(8'h01, 8'h80);
		rd_reg(8'h07, 8'h00);
	endtask : t_regs
	task automatic t_mask;
		wr_reg(8'h08, 8'hF7);
		wr_reg(8'h09, 8'h1F);
		for (int k = 4; k <= 12; k++) begin
			@(posedge clk);
			irq <= 58'h1 << k;
			vchk(16'hFFF2 - 16'(2 * k), 3'h7);
		end
		@(posedge clk);
		irq <= 58'h800;
		ib <= 1'h1;
		vchk(16'h0000, 3'h0);
		@(posedge clk);
		ib <= 1'h0;
		irq <= 58'h801;
		vchk(16'hFFF2, 3'h7);
		wr_reg(8'h00, 8'hDC);
		vchk(16'hFFDC, 3'h7);
		wr_reg(8'h09, 8'h17);
		vchk(16'hFFF2, 3'h7);
		@(posedge clk);
		irq <= 58'h4;
		vchk(16'h0000, 3'h0);
		@(posedge clk);
		irq <= 58'h0;
	endtask : t_mask
	task automatic t_exc;
		@(posedge clk);
		swi <= 1'h1;
		trap <= 1'h1;
		nmi_n <= 1'h0;
		vchk(16'hFFF8, 3'h4);
		@(posedge clk);
		trap <= 1'h0;
		vchk(16'hFFF6, 3'h5);
		@(posedge clk);
		swi <= 1'h0;
		vchk(16'hFFF4, 3'h6);
		rd_reg(8'h03, 8'h86);
		rd_reg(8'h04, 8'hF4);
		@(posedge clk);
		xb <= 1'h1;
		vchk(16'h0000, 3'h0);
		@(posedge clk);
		nmi_n <= 1'h1;
	endtask : t_exc
	task automatic t_rst;
		wr_reg(8'h01, 8'h00);
		@(posedge clk);
		cmf <= 1'h1;
		vchk(16'h0000, 3'h0);
		wr_reg(8'h01, 8'h41);
		vchk(16'hFFFC, 3'h2);
		@(posedge clk);
		wdf <= 1'h1;
		vchk(16'hFFFC, 3'h2);
		@(posedge clk);
		cmf <= 1'h0;
		vchk(16'h0000, 3'h0);
		wr_reg(8'h01, 8'h01);
		vchk(16'hFFFA, 3'h3);
		@(posedge clk);
		wdf <= 1'h0;
		rd_reg(8'h02, 8'h18);
		wr_reg(8'h02, 8'hFF);
		@(posedge clk);
		por <= 1'h1;
		repeat (2) @(posedge clk);
		vchk(16'hFFFE, 3'h1);
		@(posedge clk);
		por <= 1'h0;
		pin_n <= 1'h0;
		repeat (2) @(posedge clk);
		vchk(16'hFFFE, 3'h1);
		@(posedge clk);
		pin_n <= 1'h1;
		lvr <= 1'h1;
		repeat (2) @(posedge clk);
		vchk(16'hFFFE, 3'h1);
		chk(fetch, 16'hFFFE);
		@(posedge clk);
		lvr <= 1'h0;
		repeat (3) @(posedge clk);
		rd_reg(8'h00, 8'hF2);
		rd_reg(8'h02, 8'h07);
	endtask : t_rst
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_mask();
		t_exc();
		t_rst();
		complete_run();
	end
endmodule : vector_priority_and_reset_map_tb_top
